//--- core/bfm_pkg.sv
// constants, types and decode functions for the burst feature mode block
// assumes a single device clock; shared by the top and its two helpers
package bfm_pkg;
  // mode register addresses
  localparam logic [7:0] MA_BURST_FEATURE = 8'h01;
  localparam logic [7:0] MA_LATENCY = 8'h02;
  // field positions in burst_feature_config and the latency register
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int WC_BIT = 4;
  localparam int WR_LSB = 5;
  localparam int WR_MSB = 7;
  localparam int LAT_MSB = 3;
  // burst length codes and beat counts
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [4:0] BEATS_4 = 5'h04;
  localparam logic [4:0] BEATS_8 = 5'h08;
  localparam logic [4:0] BEATS_16 = 5'h10;
  // write recovery codes and cycle counts
  localparam logic [2:0] WR_CODE_3 = 3'h1;
  localparam logic [2:0] WR_CODE_4 = 3'h2;
  localparam logic [2:0] WR_CODE_5 = 3'h3;
  localparam logic [2:0] WR_CYC_3 = 3'h3;
  localparam logic [2:0] WR_CYC_4 = 3'h4;
  localparam logic [2:0] WR_CYC_5 = 3'h5;
  // latency codes
  localparam logic [3:0] LAT_CODE_3_1 = 4'h1;
  localparam logic [3:0] LAT_CODE_4_2 = 4'h2;
  localparam logic [3:0] LAT_CODE_5_2 = 4'h3;
  localparam logic [3:0] LAT_CODE_6_3 = 4'h4;
  localparam logic [3:0] LAT_CODE_7_4 = 4'h5;
  localparam logic [3:0] LAT_CODE_8_4 = 4'h6;
  // reset decodes
  localparam logic BT_RST = 1'b0;
  localparam logic WC_RST = 1'b0;
  localparam logic [3:0] RL_RST = 4'h3;
  localparam logic [2:0] WL_RST = 3'h1;
  // strobe toggles returned for a read of a write-only register
  localparam logic [2:0] MRR_TOGGLES = 3'h4;
  localparam logic [7:0] MRR_FILL = 8'h00;
  localparam logic [4:0] ONE_BEAT = 5'h01;
  localparam logic [2:0] ONE_CYC = 3'h1;

  typedef enum logic [1:0] {
    BFM_IDLE = 2'b01,
    BFM_BURST = 2'b10
  } bfm_state_t;

  // reserved codes fall back to the power-up value
  function automatic logic [4:0] bl_beats(input logic [2:0] code);
    unique case (code)
      BL_CODE_8: bl_beats = BEATS_8;
      BL_CODE_16: bl_beats = BEATS_16;
      default: bl_beats = BEATS_4;
    endcase
  endfunction

  function automatic logic [2:0] wr_cycles(input logic [2:0] code);
    unique case (code)
      WR_CODE_4: wr_cycles = WR_CYC_4;
      WR_CODE_5: wr_cycles = WR_CYC_5;
      default: wr_cycles = WR_CYC_3;
    endcase
  endfunction

  // returns {read latency, write latency}
  function automatic logic [6:0] rl_wl(input logic [3:0] code);
    unique case (code)
      LAT_CODE_4_2: rl_wl = {4'h4, 3'h2};
      LAT_CODE_5_2: rl_wl = {4'h5, 3'h2};
      LAT_CODE_6_3: rl_wl = {4'h6, 3'h3};
      LAT_CODE_7_4: rl_wl = {4'h7, 3'h4};
      LAT_CODE_8_4: rl_wl = {4'h8, 3'h4};
      default: rl_wl = {RL_RST, WL_RST};
    endcase
  endfunction
endpackage

//--- core/bfm_cfg_if.sv
// carrier between the mode register top and its burst helpers
// assumes all three modules sit on mclk
interface bfm_cfg_if;
  logic start;
  logic [9:0] start_col;
  logic [4:0] beats;
  logic interleave;
  logic no_wrap;
  logic write_ap;
  logic [2:0] wr_cyc;
  logic beat_valid;
  logic beat_last;
  logic [9:0] col;
  logic pre_start;

  modport ctl (
    output start, start_col, beats, interleave, no_wrap, write_ap, wr_cyc,
    input beat_valid, beat_last, col, pre_start
  );
  modport seq (
    input start, start_col, beats, interleave, no_wrap,
    output beat_valid, beat_last, col
  );
  modport rec (
    input beat_last, write_ap, wr_cyc,
    output pre_start
  );
endinterface

//--- core/bfm_burst_seq.sv
// column address generator for one burst, one beat per clock
// assumes start arrives only while no burst is running
module bfm_burst_seq (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  bfm_cfg_if.seq cfg
);
  typedef struct packed {
    logic active;
    logic [4:0] idx;
    logic [9:0] base;
    logic [9:0] col;
  } bfm_seq_t;

  bfm_seq_t q, d;

  // address of beat idx within a burst starting at base
  function automatic logic [9:0] beat_addr(input logic [9:0] base,
      input logic [4:0] idx, input logic [4:0] beats, input logic il,
      input logic nw);
    logic [9:0] mask;
    logic [9:0] step;
    mask = {5'h00, beats - bfm_pkg::ONE_BEAT};
    step = base + {5'h00, idx};
    if (nw) begin
      beat_addr = step;
    end else if (il) begin
      beat_addr = (base & ~mask) | ((base ^ {5'h00, idx}) & mask);
    end else begin
      beat_addr = (base & ~mask) | (step & mask);
    end
  endfunction

  // load on start, step until the last beat
  always_comb begin
    d = q;
    if (cfg.start) begin
      d.active = 1'b1;
      d.idx = 5'h00;
      d.base = cfg.start_col;
      d.col = cfg.start_col;
    end else if (q.active) begin
      if (cfg.beat_last) begin
        d.active = 1'b0;
      end else begin
        d.idx = q.idx + bfm_pkg::ONE_BEAT;
        d.col = beat_addr(q.base, d.idx, cfg.beats, cfg.interleave,
                          cfg.no_wrap);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign cfg.beat_valid = q.active;
  assign cfg.beat_last = q.active && (q.idx == cfg.beats - bfm_pkg::ONE_BEAT);
  assign cfg.col = q.col;
endmodule

//--- core/bfm_wr_recovery.sv
// write-recovery timer for writes with auto precharge
// assumes wr_cyc is stable in the last beat of the write burst
module bfm_wr_recovery (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  bfm_cfg_if.rec cfg
);
  typedef struct packed {
    logic pend;
    logic [2:0] cnt;
    logic pre;
  } bfm_rec_t;

  bfm_rec_t q, d;

  // count down the programmed cycles after the last write beat
  always_comb begin
    d = q;
    d.pre = 1'b0;
    if (cfg.beat_last && cfg.write_ap) begin
      d.pend = 1'b1;
      d.cnt = cfg.wr_cyc;
    end else if (q.pend) begin
      if (q.cnt == bfm_pkg::ONE_CYC) begin
        d.pend = 1'b0;
        d.pre = 1'b1;
      end else begin
        d.cnt = q.cnt - bfm_pkg::ONE_CYC;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign cfg.pre_start = q.pre;

  property p_wr_delay;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    cfg.beat_last && cfg.write_ap && cfg.wr_cyc == 3'h3 |-> ##4 cfg.pre_start;
  endproperty
  a_wr_delay: assert property (p_wr_delay) else $error("precharge late");

  c_precharge: cover property (@(posedge mclk) cfg.pre_start);
endmodule

//--- core/bfm_mode_regs.sv
// burst and latency mode registers with column burst ordering
// assumes the controller shares mclk and drives the pins synchronously
module bfm_mode_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic mrw_valid,
  input wire logic [7:0] mrw_addr,
  input wire logic [7:0] mrw_data,
  input wire logic mrr_valid,
  input wire logic [7:0] mrr_addr,
  output logic mrr_dqs,
  output logic [7:0] mrr_data,
  input wire logic col_valid,
  output logic col_ready,
  input wire logic col_write,
  input wire logic col_auto_precharge,
  input wire logic [8:0] col_addr_hi,
  output logic beat_valid,
  output logic beat_last,
  output logic [9:0] beat_col,
  output logic precharge_start,
  output logic [4:0] burst_length_beats,
  output logic burst_order_type,
  output logic wrap_control,
  output logic [2:0] write_recovery_cycles,
  output logic [3:0] read_latency,
  output logic [2:0] write_latency
);
  typedef struct packed {
    bfm_pkg::bfm_state_t st;
    logic [4:0] live_beats;
    logic live_il;
    logic live_nw;
    logic [2:0] live_wr;
    logic [3:0] rl;
    logic [2:0] wl;
    logic [4:0] beats;
    logic il;
    logic nw;
    logic wap;
    logic [2:0] mrr_cnt;
    logic dqs;
  } bfm_top_t;

  localparam bfm_top_t TOP_RST = '{
    st: bfm_pkg::BFM_IDLE,
    live_beats: bfm_pkg::BEATS_4,
    live_il: bfm_pkg::BT_RST,
    live_nw: bfm_pkg::WC_RST,
    live_wr: bfm_pkg::WR_CYC_3,
    rl: bfm_pkg::RL_RST,
    wl: bfm_pkg::WL_RST,
    beats: bfm_pkg::BEATS_4,
    il: bfm_pkg::BT_RST,
    nw: bfm_pkg::WC_RST,
    wap: 1'b0,
    mrr_cnt: 3'h0,
    dqs: 1'b0
  };

  bfm_top_t q, d;
  bfm_cfg_if cfg ();

  logic take_col;
  logic [9:0] start_col;
  logic wo_read;

  // column bit 0 never travels, so every burst starts even
  assign start_col = {col_addr_hi, 1'b0};
  assign col_ready = (q.st == bfm_pkg::BFM_IDLE);
  assign take_col = col_valid && col_ready;
  assign wo_read = mrr_valid && (mrr_addr == bfm_pkg::MA_BURST_FEATURE ||
                                 mrr_addr == bfm_pkg::MA_LATENCY);

  // register writes, burst control and strobe for reads
  always_comb begin
    d = q;
    // writes to other addresses belong to other blocks and are ignored
    if (mrw_valid && mrw_addr == bfm_pkg::MA_BURST_FEATURE) begin
      d.live_beats = bfm_pkg::bl_beats(
        mrw_data[bfm_pkg::BL_MSB:bfm_pkg::BL_LSB]);
      d.live_il = mrw_data[bfm_pkg::BT_BIT];
      d.live_nw = mrw_data[bfm_pkg::WC_BIT];
      d.live_wr = bfm_pkg::wr_cycles(
        mrw_data[bfm_pkg::WR_MSB:bfm_pkg::WR_LSB]);
    end
    if (mrw_valid && mrw_addr == bfm_pkg::MA_LATENCY) begin
      // upper bits are unused and not looked at
      {d.rl, d.wl} = bfm_pkg::rl_wl(mrw_data[bfm_pkg::LAT_MSB:0]);
    end
    unique case (q.st)
      bfm_pkg::BFM_IDLE: begin
        if (take_col) begin
          // length, order and wrap are frozen per burst so a mid-burst write to them waits
          d.st = bfm_pkg::BFM_BURST;
          d.beats = q.live_beats;
          // interleave has no sixteen-beat order; fall back to sequential
          d.il = q.live_il && (q.live_beats != bfm_pkg::BEATS_16);
          // no-wrap is honoured only for four beats
          d.nw = q.live_nw && (q.live_beats == bfm_pkg::BEATS_4);
          d.wap = col_write && col_auto_precharge;
        end
      end
      bfm_pkg::BFM_BURST: begin
        if (cfg.beat_last) begin
          d.st = bfm_pkg::BFM_IDLE;
        end
      end
    endcase
    // strobe toggles with no defined data for write-only registers
    if (wo_read) begin
      d.mrr_cnt = bfm_pkg::MRR_TOGGLES;
      d.dqs = ~q.dqs;
    end else if (q.mrr_cnt != 3'h0) begin
      d.mrr_cnt = q.mrr_cnt - bfm_pkg::ONE_CYC;
      d.dqs = (d.mrr_cnt == 3'h0) ? 1'b0 : ~q.dqs;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= TOP_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // hand the frozen burst settings and the live write recovery to the helpers
  assign cfg.start = take_col && clk_en;
  assign cfg.start_col = start_col;
  assign cfg.beats = q.beats;
  assign cfg.interleave = q.il;
  assign cfg.no_wrap = q.nw;
  assign cfg.write_ap = q.wap;
  assign cfg.wr_cyc = q.live_wr;

  bfm_burst_seq u_seq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cfg(cfg.seq)
  );

  bfm_wr_recovery u_rec (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cfg(cfg.rec)
  );

  // outputs; the decoded settings come straight from state flops
  assign beat_valid = cfg.beat_valid;
  assign beat_last = cfg.beat_last;
  assign beat_col = cfg.col;
  assign precharge_start = cfg.pre_start;
  assign burst_length_beats = q.live_beats;
  assign burst_order_type = q.live_il;
  assign wrap_control = q.live_nw;
  assign write_recovery_cycles = q.live_wr;
  assign read_latency = q.rl;
  assign write_latency = q.wl;
  assign mrr_dqs = q.dqs;
  assign mrr_data = bfm_pkg::MRR_FILL;

  // checks; clock enable gaps abandon an attempt rather than skew it
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_bl_write;
    mrw_valid && mrw_addr == 8'h01 && mrw_data[2:0] == 3'h3
      |=> burst_length_beats == 5'h08;
  endproperty
  a_bl_write: assert property (p_bl_write) else $error("length wrong");

  property p_bt_write;
    mrw_valid && mrw_addr == 8'h01 |=> burst_order_type == $past(mrw_data[3]);
  endproperty
  a_bt_write: assert property (p_bt_write) else $error("order wrong");

  property p_wr_write;
    mrw_valid && mrw_addr == 8'h01 && mrw_data[7:5] == 3'h2
      |=> write_recovery_cycles == 3'h4;
  endproperty
  a_wr_write: assert property (p_wr_write) else $error("recovery wrong");

  property p_lat_write;
    mrw_valid && mrw_addr == 8'h02 && mrw_data[3:0] == 4'h4
      |=> read_latency == 4'h6 && write_latency == 3'h3;
  endproperty
  a_lat_write: assert property (p_lat_write) else $error("latency bad");

  property p_even_start;
    take_col |=> beat_valid && beat_col[0] == 1'b0;
  endproperty
  a_even_start: assert property (p_even_start) else $error("odd start");

  property p_four_beats;
    take_col && burst_length_beats == 5'h04
      |=> beat_valid [*4] ##1 !beat_valid;
  endproperty
  a_four_beats: assert property (p_four_beats) else $error("not 4 beats");

  property p_seq_step;
    beat_valid && !beat_last && !q.il && !q.nw
      |=> (beat_col & {5'h00, q.beats - 5'h01}) ==
          (($past(beat_col) + 10'h001) & {5'h00, q.beats - 5'h01});
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("seq step");

  property p_il_step;
    beat_valid && !beat_last && q.il
      |=> beat_col[0] != $past(beat_col[0]);
  endproperty
  a_il_step: assert property (p_il_step) else $error("interleave");

  property p_nowrap_step;
    beat_valid && !beat_last && q.nw |=> beat_col == $past(beat_col) + 10'h001;
  endproperty
  a_nowrap_step: assert property (p_nowrap_step) else $error("no-wrap");

  property p_mrr_strobe;
    wo_read |=> mrr_dqs ##1 !mrr_dqs;
  endproperty
  a_mrr_strobe: assert property (p_mrr_strobe) else $error("no strobe");

  // decode of the 16-beat length, reserved lengths, wrap, five-cycle recovery and latency codes 1 and 6
  property p_bl16_write;
    mrw_valid && mrw_addr == 8'h01 && mrw_data[2:0] == 3'h4
      |=> burst_length_beats == 5'h10;
  endproperty
  a_bl16_write: assert property (p_bl16_write) else $error("len 16");

  // reserved lengths must not leave an odd beat count behind
  property p_bl_reserved;
    mrw_valid && mrw_addr == 8'h01 &&
      !(mrw_data[2:0] inside {3'h2, 3'h3, 3'h4})
      |=> burst_length_beats == 5'h04;
  endproperty
  a_bl_reserved: assert property (p_bl_reserved) else $error("len rsv");

  property p_wc_write;
    mrw_valid && mrw_addr == 8'h01 |=> wrap_control == $past(mrw_data[4]);
  endproperty
  a_wc_write: assert property (p_wc_write) else $error("wrap wrong");

  property p_wr_five;
    mrw_valid && mrw_addr == 8'h01 && mrw_data[7:5] == 3'h3
      |=> write_recovery_cycles == 3'h5;
  endproperty
  a_wr_five: assert property (p_wr_five) else $error("recovery 5");

  // upper bits of the latency byte must not disturb the decode
  property p_lat_low;
    mrw_valid && mrw_addr == 8'h02 && mrw_data[3:0] == 4'h1
      |=> read_latency == 4'h3 && write_latency == 3'h1;
  endproperty
  a_lat_low: assert property (p_lat_low) else $error("latency low");

  property p_lat_top;
    mrw_valid && mrw_addr == 8'h02 && mrw_data[3:0] == 4'h6
      |=> read_latency == 4'h8 && write_latency == 3'h4;
  endproperty
  a_lat_top: assert property (p_lat_top) else $error("latency top");

  // settings hold while nothing is written
  property p_hold;
    !mrw_valid |=> $stable(burst_length_beats) && $stable(read_latency) &&
      $stable(write_recovery_cycles);
  endproperty
  a_hold: assert property (p_hold) else $error("setting drift");

  // no new burst may be accepted over a running one
  property p_busy;
    beat_valid |-> !col_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready in burst");

  property p_il16_seq;
    take_col && q.live_beats == 5'h10 |=> !q.il;
  endproperty
  a_il16_seq: assert property (p_il16_seq) else $error("il16");

  property p_nw_bl4;
    take_col && q.live_beats != 5'h04 |=> !q.nw;
  endproperty
  a_nw_bl4: assert property (p_nw_bl4) else $error("no-wrap long");

  // the precharge request is a single pulse
  property p_pre_pulse;
    precharge_start |=> !precharge_start;
  endproperty
  a_pre_pulse: assert property (p_pre_pulse) else $error("pre pulse");

  c_bl16: cover property (take_col && burst_length_beats == 5'h10);
  c_il8: cover property (take_col && q.live_il && q.live_beats == 5'h08);
  c_nowrap: cover property (beat_valid && q.nw);
  c_mrr: cover property (wo_read);
endmodule

//--- bench/bfm_ctl_model.sv
// memory controller model: mode register writes, reads, column commands
// assumes the block samples every input on the rising edge of mclk
module bfm_ctl_model (
  input wire logic mclk,
  input wire logic col_ready,
  output logic mrw_valid,
  output logic [7:0] mrw_addr,
  output logic [7:0] mrw_data,
  output logic mrr_valid,
  output logic [7:0] mrr_addr,
  output logic col_valid,
  output logic col_write,
  output logic col_auto_precharge,
  output logic [8:0] col_addr_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_q = 8'h22;

  // idle values at time zero
  initial begin
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    col_valid = 1'b0;
    mrw_addr = 8'h00;
    mrw_data = 8'h00;
    mrr_addr = 8'h00;
    col_write = 1'b0;
    col_auto_precharge = 1'b0;
    col_addr_hi = 9'h000;
  end

  // recovery cycles are the time over the period, rounded up
  function automatic logic [2:0] wr_code(input int twr_ns);
    return 3'((twr_ns + 49) / 50 - 2);
  endfunction

  // released lines show the inverse so stale values never match
  task automatic mrw(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h01 && !(d[2:0] inside {3'h2, 3'h3, 3'h4})) return;
    if (a == 8'h02 && !(d[3:0] inside {[4'h1:4'h6]})) return;
    if (a == 8'h01) cfg_q = d;
    @(posedge mclk);
    mrw_valid <= 1'b1;
    mrw_addr <= a;
    mrw_data <= (a == 8'h02) ? {4'h0, d[3:0]} : d;
    @(posedge mclk);
    mrw_valid <= 1'b0;
    mrw_addr <= ~a;
    mrw_data <= ~d;
  endtask

  task automatic mrr(input logic [7:0] a);
    @(posedge mclk);
    mrr_valid <= 1'b1;
    mrr_addr <= a;
    @(posedge mclk);
    mrr_valid <= 1'b0;
    mrr_addr <= ~a;
  endtask

  // no-wrap only for four beats and away from page and sub-page edges
  task automatic col(input logic w, input logic ap, input logic [8:0] hi);
    int n;
    if (cfg_q[4] && (cfg_q[2:0] != 3'h2 ||
        {hi, 1'b0} inside {10'h3FE, 10'h000, 10'h1FE, 10'h200}))
      return;
    @(posedge mclk);
    col_valid <= 1'b1;
    col_write <= w;
    col_auto_precharge <= ap;
    col_addr_hi <= hi;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (col_ready !== 1'b1 && n < 40);
    col_valid <= 1'b0;
    col_addr_hi <= ~hi;
  endtask
endmodule

//--- bench/bfm_mode_regs_tb.sv
// self-checking bench for the burst and latency mode registers
// assumes the controller model drives all requests from mclk edges
module bfm_mode_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, clk_en, mrw_valid, mrr_valid, mrr_dqs;
  logic col_valid, col_ready, col_write, col_auto_precharge;
  logic beat_valid, beat_last, precharge_start;
  logic burst_order_type, wrap_control, ebt, ewc;
  logic [7:0] mrw_addr, mrw_data, mrr_addr, mrr_data;
  logic [8:0] col_addr_hi;
  logic [9:0] beat_col;
  logic [4:0] burst_length_beats, ebl;
  logic [2:0] write_recovery_cycles, write_latency, ewr, ewl;
  logic [3:0] read_latency, erl;
  logic [2:0] wl_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
  logic [7:0] cfgs [7] = '{8'h22, 8'h2A, 8'h32, 8'h3A, 8'h43, 8'h4B, 8'h64};
  logic [8:0] hs [3] = '{9'h001, 9'h006, 9'h07B};
  logic [9:0] q [$];
  int failures = 0, n_tests = 0, cyc = 0, t_last = 0, t_pre = 0;
  int last_idx = 0;

  bfm_mode_regs bfm_mode_regs_i (.mclk, .sys_rst, .clk_en, .mrw_valid,
    .mrw_addr, .mrw_data, .mrr_valid, .mrr_addr, .mrr_dqs, .mrr_data,
    .col_valid, .col_ready, .col_write, .col_auto_precharge, .col_addr_hi,
    .beat_valid, .beat_last, .beat_col, .precharge_start,
    .burst_length_beats, .burst_order_type, .wrap_control,
    .write_recovery_cycles, .read_latency, .write_latency);
  bfm_ctl_model bfm_ctl_model_i (.mclk, .col_ready, .mrw_valid, .mrw_addr,
    .mrw_data, .mrr_valid, .mrr_addr, .col_valid, .col_write,
    .col_auto_precharge, .col_addr_hi);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // beat capture; registers read before this edge's updates land
  always @(posedge mclk) begin
    cyc++;
    if (beat_valid === 1'b1) q.push_back(beat_col);
    if (beat_last === 1'b1) begin
      t_last = cyc;
      last_idx = q.size();
    end
    if (precharge_start === 1'b1) t_pre = cyc;
  end

  task automatic complete_run;
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] e,
      input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_cfg;
    n_tests++;
    if ({burst_length_beats, burst_order_type, wrap_control,
        write_recovery_cycles, read_latency, write_latency} !==
        {ebl, ebt, ewc, ewr, erl, ewl}) begin
      failures++;
      $display("ERROR settings expected %0h %0h %0h %0h %0h %0h seen %0h",
        ebl, ebt, ewc, ewr, erl, ewl, {burst_length_beats,
        burst_order_type, wrap_control, write_recovery_cycles,
        read_latency, write_latency});
    end
  endtask

  task automatic defaults;
    ebl = 5'h04;
    ebt = 1'b0;
    ewc = 1'b0;
    ewr = 3'h3;
    erl = 4'h3;
    ewl = 3'h1;
  endtask

  // write, then track what the block should now decode
  task automatic wcfg(input logic [7:0] a, input logic [7:0] d);
    bfm_ctl_model_i.mrw(a, d);
    if (a == 8'h01) begin
      ebl = (d[2:0] == 3'h3) ? 5'h08 : (d[2:0] == 3'h4) ? 5'h10 : 5'h04;
      ebt = d[3];
      ewc = d[4];
      ewr = d[7:5] + 3'h2;
    end
    if (a == 8'h02) begin
      erl = d[3:0] + 4'h2;
      ewl = wl_tab[d[2:0]];
    end
    @(posedge mclk);
    chk_cfg();
  endtask

  function automatic logic [9:0] exp_col(input logic [9:0] s, input int i);
    logic [9:0] m;
    m = 10'(ebl) - 10'h001;
    if (ewc) return s + 10'(i);
    return (s & ~m) | ((ebt ? s ^ 10'(i) : s + 10'(i)) & m);
  endfunction

  // one column command, then the whole beat train against the order
  task automatic burst(input logic w, input logic ap, input logic [8:0] hi);
    q.delete();
    last_idx = 0;
    bfm_ctl_model_i.col(w, ap, hi);
    repeat (20) @(posedge mclk);
    chk("beat count", 10'(ebl), 10'(q.size()));
    chk("last beat", 10'(ebl), 10'(last_idx));
    foreach (q[i]) chk("beat column", exp_col({hi, 1'b0}, i), q[i]);
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    defaults();
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk_cfg();
    foreach (cfgs[c]) begin
      wcfg(8'h01, cfgs[c]);
      foreach (hs[h]) burst(1'b0, 1'b0, hs[h]);
    end
    for (int k = 0; k < 3; k++) begin
      wcfg(8'h01, {bfm_ctl_model_i.wr_code(140 + 45 * k), 5'h02});
      t_pre = 0;
      burst(1'b1, 1'b1, 9'h001);
      chk("precharge delay", 10'(ewr + 3'h1), 10'(t_pre - t_last));
    end
    t_pre = 0;
    burst(1'b1, 1'b0, 9'h002);
    chk("no precharge", 10'h000, 10'(t_pre));
    for (int c = 1; c <= 6; c++) wcfg(8'h02, 8'(c));
    wcfg(8'h03, 8'h5A);
    clk_en <= 1'b0;
    bfm_ctl_model_i.mrw(8'h01, 8'h43);
    @(posedge mclk);
    clk_en <= 1'b1;
    chk_cfg();
    foreach (hs[j]) begin
      bfm_ctl_model_i.mrr(8'(j + (j / 2) * 3 + 1));
      for (int i = 0; i < 5; i++) begin
        @(posedge mclk);
        chk("read strobe", {9'h0, j < 2 && i < 4 && i % 2 == 0},
          {9'h0, mrr_dqs});
        chk("read data", 10'h000, {2'h0, mrr_data});
      end
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    defaults();
    @(posedge mclk);
    chk_cfg();
    complete_run();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule
